// >>> rtl/flash_gate_defs.svh
// Offsets, field positions, reset values and link counts for the flash state gate.
// Assumes inclusion by bare name from the gate module.
`ifndef FLASH_GATE_DEFS_SVH
`define FLASH_GATE_DEFS_SVH
// Register byte offsets
`define OFF_VCFG 8'h00
`define OFF_NVCFG 8'h04
`define OFF_STAT 8'h08
// Volatile configuration: bit 3 low enables entry, [1:0] line width
`define VCFG_AOR_N 3
`define VCFG_MASK 4'hb
`define VCFG_RST 4'h8
// Nonvolatile configuration: [11:9] boot mode, 3'b111 is off
`define NV_AOR_HI 11
`define NV_AOR_LO 9
`define NV_AOR_OFF 3'h7
`define NV_AOR_QUAD 3'h0
`define NV_AOR_DUAL 3'h1
`define NV_RST 12'he00
// Line width codes
`define W_ONE 2'h0
`define W_TWO 2'h1
`define W_FOUR 2'h2
// Link frame shape
`define CMD_BITS 6'h08
`define ADDR_BITS 6'h18
`define FAST_READ_CODE 8'h0b
`define CNT_MAX 6'h3f
// Rescue burst lengths in clocks
`define BURST_0 6'h07
`define BURST_1 6'h09
`define BURST_2 6'h0d
`define BURST_3 6'h11
`define BURST_4 6'h19
`define BURST_5 6'h21
`define BURST_LAST 3'h5
// Pin synchroniser idle pattern: chip select and reset pin high
`define PIN_IDLE 7'h06
`endif

// >>> rtl/flash_gate_pkg.sv
// Types shared by the flash state gate and its bench.
// Assumes flash_gate_defs.svh is on the include path.
`default_nettype none
package flash_gate_pkg;
  typedef enum logic [1:0] {
    ST_STANDBY,
    ST_BUSY,
    ST_SP_SUSP,
    ST_E_SUSP
  } state_t;
  typedef enum logic [3:0] {
    CLS_READ_MEM,
    CLS_READ_STAT,
    CLS_PROGRAM,
    CLS_ERASE_SECT,
    CLS_ERASE_SUB,
    CLS_WRITE_NV,
    CLS_WRITE_VOL,
    CLS_SUSPEND,
    CLS_RESUME
  } cmd_cls_t;
endpackage : flash_gate_pkg
`default_nettype wire

// >>> rtl/flash_state_gate.sv
// State gate and address-only read mode control of a serial flash.
// Assumes a command decoder feeding classified requests and link pins from another clock domain.
`include "flash_gate_defs.svh"
`default_nettype none
module flash_state_gate #(
  parameter int SECT_W = 10
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_ff,
  // Link pins
  input wire logic sclk_pin,
  input wire logic cs_n_pin,
  input wire logic [3:0] io_pin,
  input wire logic hw_rst_n_pin,
  // Command classes from the decoder
  input wire logic cmd_req,
  input wire logic [3:0] cmd_class,
  input wire logic [SECT_W-1:0] cmd_sector,
  input wire logic op_done,
  // Verdicts and mode
  output logic cmd_ack_ff,
  output logic cmd_ok_ff,
  output logic data_unsure_ff,
  output logic address_only_read_mode_ff,
  output logic frame_aor_ff,
  output var flash_gate_pkg::state_t state_ff
);

  // Synchronisers: s1 feeds only s2, s3 keeps history for edges
  logic [6:0] s1_ff;
  logic [6:0] s2_ff;
  logic [6:0] s3_ff;
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      s1_ff <= `PIN_IDLE;
      s2_ff <= `PIN_IDLE;
      s3_ff <= `PIN_IDLE;
    end
    else
    begin
      s1_ff <= {io_pin, hw_rst_n_pin, cs_n_pin, sclk_pin};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  logic sclk_rise;
  logic cs_fall;
  logic cs_rise;
  logic cs_low;
  logic io_line0;
  assign sclk_rise = s2_ff[0] & ~s3_ff[0];
  assign cs_fall = ~s2_ff[1] & s3_ff[1];
  assign cs_rise = s2_ff[1] & ~s3_ff[1];
  assign cs_low = ~s2_ff[1];
  assign io_line0 = s2_ff[3];

  // Clocks a field takes at a given line width
  function automatic logic [5:0] field_clks(input logic [5:0] bits, input logic [1:0] wc);
    case (wc)
      `W_TWO: field_clks = bits >> 1;
      `W_FOUR: field_clks = bits >> 2;
      default: field_clks = bits;
    endcase
  endfunction : field_clks

  function automatic logic [5:0] burst_len(input logic [2:0] step);
    case (step)
      3'h0: burst_len = `BURST_0;
      3'h1: burst_len = `BURST_1;
      3'h2: burst_len = `BURST_2;
      3'h3: burst_len = `BURST_3;
      3'h4: burst_len = `BURST_4;
      default: burst_len = `BURST_5;
    endcase
  endfunction : burst_len

  function automatic logic [1:0] nv_width(input logic [2:0] mode);
    case (mode)
      `NV_AOR_QUAD: nv_width = `W_FOUR;
      `NV_AOR_DUAL: nv_width = `W_TWO;
      default: nv_width = `W_ONE;
    endcase
  endfunction : nv_width

  // Configuration registers
  logic [3:0] vcfg_ff;
  logic [11:0] nvcfg_ff;
  logic boot_pend_ff;
  logic [1:0] wc;
  logic [2:0] nv_mode;
  logic nv_on;
  assign wc = vcfg_ff[1:0];
  assign nv_mode = nvcfg_ff[`NV_AOR_HI:`NV_AOR_LO];
  assign nv_on = nv_mode != `NV_AOR_OFF;

  // Frame tracking
  logic [5:0] clk_cnt_ff;
  logic [7:0] cmd_sh_ff;
  logic [5:0] cmd_clks;
  logic [5:0] dummy_at;
  assign cmd_clks = frame_aor_ff ? 6'h00 : field_clks(`CMD_BITS, wc);
  assign dummy_at = 6'(cmd_clks + field_clks(`ADDR_BITS, wc));

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      frame_aor_ff <= 1'b0;
    else if (cs_fall)
      frame_aor_ff <= address_only_read_mode_ff;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst | cs_fall)
      clk_cnt_ff <= 6'h00;
    else if (sclk_rise & cs_low & (clk_cnt_ff != `CNT_MAX))
      clk_cnt_ff <= 6'(clk_cnt_ff + 6'h01);
  end

  // Opcode shift follows the active width; wide modes put opcode bits on several lines
  always_ff @(posedge core_clk)
  begin
    if (sys_rst | cs_fall)
      cmd_sh_ff <= 8'h00;
    else if (sclk_rise & cs_low & (clk_cnt_ff < cmd_clks))
    begin
      case (wc)
        `W_TWO: cmd_sh_ff <= {cmd_sh_ff[5:0], s2_ff[4:3]};
        `W_FOUR: cmd_sh_ff <= {cmd_sh_ff[3:0], s2_ff[6:3]};
        default: cmd_sh_ff <= {cmd_sh_ff[6:0], io_line0};
      endcase
    end
  end

  // Continuation taken from line 0 alone; lines 3..1 not looked at here
  logic first_dummy;
  logic fast_rd;
  logic continuation_bit;
  logic enter_ev;
  logic exit_ev;
  assign first_dummy = sclk_rise & cs_low & (clk_cnt_ff == dummy_at);
  assign fast_rd = frame_aor_ff | (cmd_sh_ff == `FAST_READ_CODE);
  assign continuation_bit = io_line0;
  assign enter_ev = first_dummy & fast_rd & ~continuation_bit & ~address_only_read_mode_ff
                    & ~vcfg_ff[`VCFG_AOR_N];
  assign exit_ev = first_dummy & fast_rd & continuation_bit & address_only_read_mode_ff;

  // Rescue bursts: counted at deselect; a burst of 7 restarts the series
  logic [2:0] rec_step_ff;
  logic rescue_ev;
  assign rescue_ev = cs_rise & (rec_step_ff == `BURST_LAST) & (clk_cnt_ff == burst_len(`BURST_LAST));

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      rec_step_ff <= 3'h0;
    else if (cs_rise)
    begin
      if (rescue_ev)
        rec_step_ff <= 3'h0;
      else if (clk_cnt_ff == burst_len(rec_step_ff))
        rec_step_ff <= 3'(rec_step_ff + 3'h1);
      else if (clk_cnt_ff == `BURST_0)
        rec_step_ff <= 3'h1;
      else
        rec_step_ff <= 3'h0;
    end
  end

  // Reset pin; in four-line mode only honoured while deselected
  logic pin_restore;
  assign pin_restore = ~s2_ff[2] & ((wc != `W_FOUR) | ~cs_low);

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      boot_pend_ff <= 1'b1;
    else
      boot_pend_ff <= 1'b0;
  end

  // Mode flop; boot value caught one edge after reset release
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      address_only_read_mode_ff <= 1'b0;
    else if (boot_pend_ff | pin_restore)
      address_only_read_mode_ff <= nv_on;
    else if (rescue_ev | exit_ev)
      address_only_read_mode_ff <= 1'b0;
    else if (enter_ev)
      address_only_read_mode_ff <= 1'b1;
  end

  // Hardware set of bit 3 wins over a software write in the same cycle
  logic [3:0] nxt_vcfg;
  logic bus_vcfg_wr;
  assign bus_vcfg_wr = reg_wr & (reg_addr == `OFF_VCFG);
  always_comb
  begin
    nxt_vcfg = vcfg_ff;
    if (boot_pend_ff | pin_restore)
      nxt_vcfg = {~nv_on, 1'b0, nv_width(nv_mode)};
    else
    begin
      if (bus_vcfg_wr)
        nxt_vcfg = reg_wdata[3:0] & `VCFG_MASK;
      if (rescue_ev | exit_ev)
        nxt_vcfg[`VCFG_AOR_N] = 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      vcfg_ff <= `VCFG_RST;
    else
      vcfg_ff <= nxt_vcfg;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      nvcfg_ff <= `NV_RST;
    else if (reg_wr & (reg_addr == `OFF_NVCFG))
      nvcfg_ff <= reg_wdata[11:0];
  end

  // Read data for one cycle only; unmapped reads give zero
  always_ff @(posedge core_clk)
  begin
    if (sys_rst | ~reg_rd)
      reg_rdata_ff <= 32'h0000_0000;
    else
    begin
      case (reg_addr)
        `OFF_VCFG: reg_rdata_ff <= {28'h000_0000, vcfg_ff};
        `OFF_NVCFG: reg_rdata_ff <= {20'h0_0000, nvcfg_ff};
        `OFF_STAT: reg_rdata_ff <= {25'h000_0000, rec_step_ff, frame_aor_ff,
                                    address_only_read_mode_ff, state_ff};
        default: reg_rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // Operation gate
  logic [SECT_W-1:0] erase_sect_ff;
  logic busy_erase_ff;
  logic hit;
  logic ok;
  assign hit = cmd_sector == erase_sect_ff;

  always_comb
  begin
    ok = 1'b0;
    case (flash_gate_pkg::cmd_cls_t'(cmd_class))
      flash_gate_pkg::CLS_READ_STAT: ok = 1'b1;
      flash_gate_pkg::CLS_READ_MEM: ok = state_ff != flash_gate_pkg::ST_BUSY;
      flash_gate_pkg::CLS_PROGRAM: ok = (state_ff == flash_gate_pkg::ST_STANDBY)
                                        | ((state_ff == flash_gate_pkg::ST_E_SUSP) & ~hit);
      flash_gate_pkg::CLS_ERASE_SECT,
      flash_gate_pkg::CLS_ERASE_SUB: ok = state_ff == flash_gate_pkg::ST_STANDBY;
      flash_gate_pkg::CLS_WRITE_NV: ok = state_ff == flash_gate_pkg::ST_STANDBY;
      flash_gate_pkg::CLS_WRITE_VOL: ok = state_ff != flash_gate_pkg::ST_BUSY;
      flash_gate_pkg::CLS_SUSPEND: ok = state_ff == flash_gate_pkg::ST_BUSY;
      flash_gate_pkg::CLS_RESUME: ok = (state_ff == flash_gate_pkg::ST_SP_SUSP)
                                       | (state_ff == flash_gate_pkg::ST_E_SUSP);
      default: ok = 1'b0;
    endcase
  end

  logic take;
  assign take = cmd_req & ok;

  // Programs inside erase suspend run beside the suspended erase; state stays put
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      state_ff <= flash_gate_pkg::ST_STANDBY;
    else if (op_done & (state_ff == flash_gate_pkg::ST_BUSY))
      state_ff <= flash_gate_pkg::ST_STANDBY;
    else if (take)
    begin
      case (flash_gate_pkg::cmd_cls_t'(cmd_class))
        flash_gate_pkg::CLS_PROGRAM,
        flash_gate_pkg::CLS_ERASE_SECT,
        flash_gate_pkg::CLS_ERASE_SUB,
        flash_gate_pkg::CLS_WRITE_NV:
          if (state_ff == flash_gate_pkg::ST_STANDBY)
            state_ff <= flash_gate_pkg::ST_BUSY;
        flash_gate_pkg::CLS_SUSPEND:
          state_ff <= busy_erase_ff ? flash_gate_pkg::ST_E_SUSP : flash_gate_pkg::ST_SP_SUSP;
        flash_gate_pkg::CLS_RESUME: state_ff <= flash_gate_pkg::ST_BUSY;
        default: state_ff <= state_ff;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      busy_erase_ff <= 1'b0;
      erase_sect_ff <= '0;
    end
    else if (take & (state_ff == flash_gate_pkg::ST_STANDBY))
    begin
      busy_erase_ff <= cmd_class == flash_gate_pkg::CLS_ERASE_SECT;
      if (cmd_class == flash_gate_pkg::CLS_ERASE_SECT)
        erase_sect_ff <= cmd_sector;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cmd_ack_ff <= 1'b0;
      cmd_ok_ff <= 1'b0;
      data_unsure_ff <= 1'b0;
    end
    else
    begin
      cmd_ack_ff <= cmd_req;
      cmd_ok_ff <= take;
      data_unsure_ff <= take & (cmd_class == flash_gate_pkg::CLS_READ_MEM)
                        & (state_ff == flash_gate_pkg::ST_E_SUSP) & hit;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  suspend_gate_a: assert property (cmd_req && cmd_class == flash_gate_pkg::CLS_SUSPEND
    && state_ff != flash_gate_pkg::ST_BUSY |=> cmd_ack_ff && !cmd_ok_ff)
    else $error("suspend taken outside busy");
  status_read_a: assert property (cmd_req && cmd_class == flash_gate_pkg::CLS_READ_STAT
    |=> cmd_ok_ff) else $error("status read refused");
  busy_read_a: assert property (cmd_req && cmd_class == flash_gate_pkg::CLS_READ_MEM
    && state_ff == flash_gate_pkg::ST_BUSY |=> !cmd_ok_ff) else $error("array read taken while busy");
  erase_std_a: assert property (cmd_req && (cmd_class == flash_gate_pkg::CLS_ERASE_SECT
    || cmd_class == flash_gate_pkg::CLS_ERASE_SUB) && state_ff != flash_gate_pkg::ST_STANDBY
    |=> !cmd_ok_ff) else $error("erase taken outside standby");
  nv_write_a: assert property (cmd_req && cmd_class == flash_gate_pkg::CLS_WRITE_NV
    |=> cmd_ok_ff == ($past(state_ff) == flash_gate_pkg::ST_STANDBY)) else $error("nv write verdict wrong");
  vol_write_a: assert property (cmd_req && cmd_class == flash_gate_pkg::CLS_WRITE_VOL
    |=> cmd_ok_ff != ($past(state_ff) == flash_gate_pkg::ST_BUSY)) else $error("volatile write verdict wrong");
  prog_susp_a: assert property (cmd_req && cmd_class == flash_gate_pkg::CLS_PROGRAM
    && state_ff == flash_gate_pkg::ST_SP_SUSP |=> !cmd_ok_ff) else $error("program taken in program suspend");
  esusp_hit_a: assert property (cmd_req && cmd_class == flash_gate_pkg::CLS_PROGRAM
    && state_ff == flash_gate_pkg::ST_E_SUSP |=> cmd_ok_ff == ($past(cmd_sector) != erase_sect_ff))
    else $error("erase suspend sector compare wrong");
  mode_enter_a: assert property (enter_ev && !boot_pend_ff && !pin_restore
    |=> address_only_read_mode_ff ##1 address_only_read_mode_ff || !vcfg_ff[`VCFG_AOR_N] || exit_ev)
    else $error("mode entry lost");
  mode_exit_a: assert property (exit_ev && !boot_pend_ff && !pin_restore
    |=> !address_only_read_mode_ff && vcfg_ff[`VCFG_AOR_N]) else $error("mode exit incomplete");
  rescue_keep_a: assert property (rescue_ev && !boot_pend_ff && !pin_restore && !cmd_req && !op_done
    |=> !address_only_read_mode_ff && $stable(state_ff)) else $error("rescue wrong");
  boot_mode_a: assert property (boot_pend_ff |=> address_only_read_mode_ff == $past(nv_on))
    else $error("boot mode wrong");
  pin_rst_a: assert property (pin_restore |=> address_only_read_mode_ff == $past(nv_on))
    else $error("pin reset restore wrong");
  frame_mode_a: assert property (cs_fall |=> frame_aor_ff == $past(address_only_read_mode_ff))
    else $error("frame mode latch wrong");

  enter_c: cover property (enter_ev ##[1:400] exit_ev);
  rescue_c: cover property (address_only_read_mode_ff ##1 rescue_ev);
  esusp_prog_c: cover property (take && state_ff == flash_gate_pkg::ST_E_SUSP
    && cmd_class == flash_gate_pkg::CLS_PROGRAM);
  unsure_c: cover property (data_unsure_ff);

endmodule : flash_state_gate
`default_nettype wire

// >>> verif/flash_host_model.sv
// Host side of the serial link: clock, select and four data lines.
// Assumes the bench calls one task at a time; the clock stands still between frames.
`default_nettype none
module flash_host_model (
  // Link pins
  output var logic sclk,
  output var logic cs_n,
  output var logic [3:0] io
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    io = 4'h5;
  end

  // One 48 ns clock, data changed while the clock is low
  task tick;
    #12 sclk = 1'b1;
    #24 sclk = 0;
    #12;
  endtask : tick

  // Released lines show the inverse so a stale value never looks valid
  task release_bus;
    #12 cs_n = 1'b1;
    io = ~io;
    #48;
  endtask : release_bus

  // Optional opcode, address, continuation bit on line 0 at the first dummy clock
  task frame(input int w, input bit with_op, input logic [7:0] opc, input logic cont, input logic [2:0] hi);
    logic [31:0] sh;
    int n;
    sh = with_op ? {opc, 24'($urandom)} : {24'($urandom), 8'h00};
    n = (with_op ? 8 / w : 0) + 24 / w;
    cs_n = 1'b0;
    repeat (n)
    begin
      io = (w == 4) ? sh[31:28] : (w == 2) ? {~io[3:2], sh[31:30]} : {~io[3:1], sh[31]};
      sh = sh << w;
      tick();
    end
    io = {hi, cont};
    tick();
    io = ~io;
    tick();
    release_bus();
  endtask : frame

  // Rescue burst; all four lines high for the whole select-low period
  task burst(input int n);
    cs_n = 1'b0;
    io = 4'hf;
    repeat (n) tick();
    release_bus();
  endtask : burst

  // Opcode-only frame on line 0, as the software reset pair needs
  task op_only(input logic [7:0] opc);
    logic [7:0] sh;
    sh = opc;
    cs_n = 1'b0;
    repeat (8)
    begin
      io = {3'h7, sh[7]};
      sh = sh << 1;
      tick();
    end
    release_bus();
  endtask : op_only
endmodule : flash_host_model
`default_nettype wire

// >>> verif/flash_state_gate_test.sv
// Self-checking bench for the flash state gate: register port, command gate, link.
// Assumes flash_gate_pkg and flash_host_model are compiled first.
`default_nettype none
module flash_state_gate_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata_ff;
  logic sclk_pin, cs_n_pin;
  logic hw_rst_n_pin = 1'b1;
  logic [3:0] io_pin;
  logic cmd_req = 1'b0;
  logic [3:0] cmd_class = 4'h0;
  logic [9:0] cmd_sector = 10'h000;
  logic op_done = 1'b0;
  logic cmd_ack_ff, cmd_ok_ff, data_unsure_ff, address_only_read_mode_ff, frame_aor_ff;
  flash_gate_pkg::state_t state_ff;
  int errors = 0;
  int samples_checked = 0;
  // Reference model
  int st = 0;
  int esect = 0;
  flash_gate_pkg::cmd_cls_t kind = flash_gate_pkg::CLS_READ_MEM;
  flash_gate_pkg::cmd_cls_t rc;
  logic [3:0] vcfg_m = 4'h8;
  logic mode_m = 1'b0;
  int lens[13] = '{7, 9, 10, 13, 17, 25, 33, 7, 9, 13, 17, 25, 33};
  logic aor_m = 1'b0;
  // Reset pair opcodes; values arbitrary, the gate does not decode them
  localparam logic [7:0] RST_EN_CODE = 8'h5a;
  localparam logic [7:0] RST_MEM_CODE = 8'ha5;

  always #2.5 core_clk = ~core_clk;

  // Frame kind follows the model's mode at select
  always @(negedge cs_n_pin)
    aor_m = mode_m;

  flash_state_gate dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin),
    .io_pin(io_pin), .hw_rst_n_pin(hw_rst_n_pin), .cmd_req(cmd_req), .cmd_class(cmd_class),
    .cmd_sector(cmd_sector), .op_done(op_done), .cmd_ack_ff(cmd_ack_ff), .cmd_ok_ff(cmd_ok_ff),
    .data_unsure_ff(data_unsure_ff), .address_only_read_mode_ff(address_only_read_mode_ff),
    .frame_aor_ff(frame_aor_ff), .state_ff(state_ff));
  flash_host_model host (.sclk(sclk_pin), .cs_n(cs_n_pin), .io(io_pin));

  task end_sim;
    $display("Checks %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(what, exp, reg_rdata_ff);
  endtask : rd_chk

  // Pin events need a few core cycles to cross the synchroniser
  task link_chk;
    repeat (8) @(posedge core_clk);
    #1 chk("mode", {31'h0, mode_m}, {31'h0, address_only_read_mode_ff});
    chk("frame mode", {31'h0, aor_m}, {31'h0, frame_aor_ff});
    rd_chk(8'h00, {28'h0, vcfg_m}, "vcfg");
  endtask : link_chk

  task pin_reset;
    @(posedge core_clk);
    hw_rst_n_pin <= 1'b0;
    repeat (3) @(posedge core_clk);
    hw_rst_n_pin <= 1'b1;
  endtask : pin_reset

  task cmd(input flash_gate_pkg::cmd_cls_t c, input int sec, input bit done);
    bit ok;
    bit unsure;
    case (c)
      flash_gate_pkg::CLS_READ_MEM: ok = st != 1;
      flash_gate_pkg::CLS_READ_STAT: ok = 1'b1;
      flash_gate_pkg::CLS_PROGRAM: ok = st == 0 || (st == 3 && sec != esect);
      flash_gate_pkg::CLS_WRITE_VOL: ok = st != 1;
      flash_gate_pkg::CLS_SUSPEND: ok = st == 1;
      flash_gate_pkg::CLS_RESUME: ok = st >= 2;
      default: ok = st == 0;
    endcase
    unsure = ok && c == flash_gate_pkg::CLS_READ_MEM && st == 3 && sec == esect;
    @(posedge core_clk);
    cmd_req <= 1'b1;
    cmd_class <= c;
    cmd_sector <= 10'(sec);
    op_done <= done;
    @(posedge core_clk);
    cmd_req <= 1'b0;
    op_done <= 1'b0;
    if (done && st == 1)
      st = 0;
    else if (ok && st == 0 && c >= flash_gate_pkg::CLS_PROGRAM && c <= flash_gate_pkg::CLS_WRITE_NV)
    begin
      st = 1;
      kind = c;
      if (c == flash_gate_pkg::CLS_ERASE_SECT)
        esect = sec;
    end
    else if (ok && c == flash_gate_pkg::CLS_SUSPEND)
      st = (kind == flash_gate_pkg::CLS_ERASE_SECT) ? 3 : 2;
    else if (ok && c == flash_gate_pkg::CLS_RESUME)
      st = 1;
    #1 chk("ack", 32'h1, {31'h0, cmd_ack_ff});
    chk("ok", {31'h0, ok}, {31'h0, cmd_ok_ff});
    // Only the erase-suspended sector is flagged; other suspends read clean
    chk("unsure", {31'h0, unsure}, {31'h0, data_unsure_ff});
    chk("state", st, {30'h0, state_ff});
  endtask : cmd

  initial
  begin
    void'($urandom(32'h533d));
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    rd_chk(8'h00, 32'h8, "vcfg reset");
    rd_chk(8'h04, 32'he00, "nvcfg reset");
    rd_chk(8'h08, 32'h0, "status reset");
    wr(8'h0c, 32'hffff_ffff);
    rd_chk(8'h0c, 32'h0, "unmapped");
    // Bits outside the writable mask are dropped
    wr(8'h00, 32'hffff_fff4);
    vcfg_m = 4'h0;
    host.frame(1, 1'b1, 8'h03, 1'b0, 3'h7);
    link_chk();
    host.frame(1, 1'b1, 8'h0b, 1'b0, 3'h7);
    mode_m = 1'b1;
    link_chk();
    host.frame(1, 1'b0, 8'h00, 1'b0, 3'h7);
    link_chk();
    host.frame(1, 1'b0, 8'h00, 1'b1, 3'h0);
    mode_m = 1'b0;
    vcfg_m = 4'h8;
    link_chk();
    host.frame(1, 1'b1, 8'h0b, 1'b0, 3'h7);
    link_chk();
    wr(8'h00, 32'h0);
    vcfg_m = 4'h0;
    host.frame(1, 1'b1, 8'h0b, 1'b0, 3'h7);
    pin_reset();
    vcfg_m = 4'h8;
    link_chk();
    wr(8'h04, 32'h200);
    rd_chk(8'h04, 32'h200, "nvcfg");
    pin_reset();
    mode_m = 1'b1;
    vcfg_m = 4'h1;
    link_chk();
    host.frame(2, 1'b0, 8'h00, 1'b0, 3'h7);
    link_chk();
    host.frame(2, 1'b0, 8'h00, 1'b1, 3'h0);
    mode_m = 1'b0;
    vcfg_m = 4'h9;
    link_chk();
    wr(8'h00, 32'h2);
    vcfg_m = 4'h2;
    host.frame(4, 1'b1, 8'h0b, 1'b0, 3'h7);
    mode_m = 1'b1;
    link_chk();
    // Four-line mode: reset pin ignored while selected
    fork
      host.frame(4, 1'b0, 8'h00, 1'b0, 3'h7);
      pin_reset();
    join
    link_chk();
    host.frame(4, 1'b0, 8'h00, 1'b1, 3'h0);
    mode_m = 1'b0;
    vcfg_m = 4'ha;
    link_chk();
    // Broken series first, then a full one while an erase runs
    wr(8'h00, 32'h0);
    vcfg_m = 4'h0;
    cmd(flash_gate_pkg::CLS_ERASE_SECT, 2, 1'b0);
    foreach (lens[i])
    begin
      host.burst(lens[i]);
      if (i == 6)
        link_chk();
    end
    vcfg_m = 4'h8;
    link_chk();
    host.op_only(RST_EN_CODE);
    host.op_only(RST_MEM_CODE);
    link_chk();
    cmd(flash_gate_pkg::CLS_READ_STAT, 0, 1'b0);
    cmd(flash_gate_pkg::CLS_SUSPEND, 0, 1'b0);
    cmd(flash_gate_pkg::CLS_PROGRAM, 2, 1'b0);
    cmd(flash_gate_pkg::CLS_PROGRAM, 3, 1'b0);
    cmd(flash_gate_pkg::CLS_READ_MEM, 2, 1'b0);
    cmd(flash_gate_pkg::CLS_RESUME, 0, 1'b0);
    cmd(flash_gate_pkg::CLS_READ_STAT, 0, 1'b1);
    repeat (400)
    begin
      rc = flash_gate_pkg::cmd_cls_t'($urandom_range(8));
      // Suspend of a nonvolatile write has no defined target state
      if (st == 1 && kind == flash_gate_pkg::CLS_WRITE_NV && rc == flash_gate_pkg::CLS_SUSPEND)
        rc = flash_gate_pkg::CLS_READ_STAT;
      cmd(rc, $urandom_range(3), $urandom_range(7) == 0);
    end
    end_sim();
  end

  initial
  begin
    #300000;
    errors++;
    end_sim();
  end
endmodule : flash_state_gate_test
`default_nettype wire
